// ---- hw/cocd_map.svh ----
/*
  Offsets, field positions, reset values and clock frequencies of the
  option decoder.
  Assumes inclusion by bare name from the package and the top module.
*/
`ifndef COCD_MAP_SVH
`define COCD_MAP_SVH

// Register byte offsets.
`define COCD_OFS_OPTION 8'h00
`define COCD_OFS_STATUS 8'h04
`define COCD_OFS_MASK 8'h08
`define COCD_OFS_FLAGS 8'h0C

// Option word field positions.
`define COCD_POS_PRESC 0
`define COCD_POS_FILT 3
`define COCD_POS_SRC 4
`define COCD_POS_WDT 7
`define COCD_POS_RSTPIN 9
`define COCD_POS_SECURE 10
`define COCD_POS_LOWPWR 11
`define COCD_POS_LVL 12

// Event bits of the status and mask registers.
`define COCD_EV_LVRESET 0
`define COCD_EV_BELOW24 1
`define COCD_EV_BELOW36 2
`define COCD_EV_EXTRST 3
`define COCD_EV_BADOPT 4
`define COCD_EV_W 5

// Reset values.
`define COCD_MASK_RST 5'h00
`define COCD_STATUS_RST 5'h00

// Internal RC and real-time crystal frequencies in hertz.
`define COCD_IRC_HZ 16000000
`define COCD_RTC_HZ 32768

// Lowest prescale code that the noise filter allows.
`define COCD_PRESC_MIN_FILT 3'h2

`endif

// ---- hw/cocd_option_decode.sv ----
/*
  Option decoder: latches the one-time option fuses at reset release and
  drives prescaler, clock source, pin reuse, watchdog, reset pin, ROM
  protection, low-power and low-voltage policy. AXI4-Lite gives read
  access to the latched options, a sticky event status with mask, and
  the low-voltage indicator flags.
  Assumes the fuse word and detector levels are synchronous to sys_clk
  and that the fuse word is stable while resetn is low.
*/
`include "cocd_map.svh"

////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Instruction cycle divides high clock by 1..128.
// - Filter on limits divide to 4..128.
// - Filter off allows every divide 1..128.
// - Same prescaler serves the low clock.
// - Internal RC frees both oscillator pins as GPIO.
// - Internal RC with crystal on oscillator pins.
// - External RC on input, output pin GPIO.
// - Three external crystal choices are offered.
// - Always-on watchdog runs in every mode.
// - Enable halts watchdog asleep; disable stops it.
// - Reset option makes pin external reset.
// - Port option makes pin open-drain bit.
// - Security option blocks ROM readout.
// - Lowest level resets below 2.1 V.
// - Middle level resets 2.1 V, flags 2.4 V.
// - Highest level resets 2.4 V, flags 3.6 V.
module cocd_option_decode
  import cocd_pkg::*;
#(
  parameter int PRESC_W = 3,
  parameter int ADDR_W = 8
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic resetn,
  // Option fuses and supply detector.
  input wire cocd_fuse_s fuse_word,
  input wire logic supply_below_2v1,
  input wire logic supply_below_2v4,
  input wire logic supply_below_3v6,
  // Core state.
  input wire logic sleep_mode,
  input wire logic ext_reset_n_pin,
  input wire logic rom_read_req,
  // Oscillator and shared pins.
  input wire logic osc_in_pin,
  input wire logic osc_out_pin,
  input wire logic port1_bit2_in,
  input wire logic osc_in_o,
  input wire logic osc_out_o,
  input wire logic port1_bit2_o,
  // Decoded controls.
  output logic [PRESC_W-1:0] cpu_div_log2,
  output logic [5:0] clk_src_sel,
  output logic osc_in_oe,
  output logic osc_out_oe,
  output logic osc_in_out,
  output logic osc_out_out,
  output logic port1_bit2_oe,
  output logic port1_bit2_out,
  output logic port1_bit2_function,
  output logic wdt_run,
  output logic rom_read_grant,
  output logic low_power_en,
  output logic chip_reset_req,
  output logic supply_below_2v4_flag,
  output logic supply_below_3v6_flag,
  output logic irq,
  // AXI4-Lite slave.
  input wire logic [ADDR_W-1:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [ADDR_W-1:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready
);

  if (PRESC_W != 3) begin : g_bad_presc
    $error("PRESC_W must be 3 for eight divide ratios");
  end
  if (ADDR_W < 4) begin : g_bad_addr
    $error("ADDR_W must hold the register offsets");
  end

  //////////////////////////////////////////////////////////////////////
  // Option latch.
  cocd_opt_s opt_ff;
  cocd_opt_s nxt_opt;
  logic latched_ff;
  logic bad_opt_ff;

  always_comb begin
    nxt_opt.presc = fuse_word.presc;
    nxt_opt.filter = fuse_word.filter;
    // With the filter on, divide 1 and 2 are lifted to divide 4.
    if (fuse_word.filter && fuse_word.presc < `COCD_PRESC_MIN_FILT) begin
      nxt_opt.presc = `COCD_PRESC_MIN_FILT;
    end
    unique case (fuse_word.src)
      3'h0: nxt_opt.src = COCD_SRC_IRC;
      3'h1: nxt_opt.src = COCD_SRC_IRC_RTC;
      3'h2: nxt_opt.src = COCD_SRC_EXT_RC;
      3'h3: nxt_opt.src = COCD_SRC_XTAL_LOW;
      3'h4: nxt_opt.src = COCD_SRC_XTAL_HIGH;
      default: nxt_opt.src = COCD_SRC_XTAL_STD;
    endcase
    unique case (fuse_word.wdt)
      2'h0: nxt_opt.wdt = COCD_WDT_ALWAYS;
      2'h1: nxt_opt.wdt = COCD_WDT_ENABLE;
      default: nxt_opt.wdt = COCD_WDT_DISABLE;
    endcase
    nxt_opt.reset_pin = fuse_word.reset_pin;
    nxt_opt.secure = fuse_word.secure;
    nxt_opt.low_power = fuse_word.low_power;
    unique case (fuse_word.lvl)
      2'h0: nxt_opt.lvl = COCD_LVL_LOW;
      2'h1: nxt_opt.lvl = COCD_LVL_MID;
      default: nxt_opt.lvl = COCD_LVL_HIGH;
    endcase
  end

  // Options are caught once, on the first edge after reset release.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      opt_ff <= '{presc: 3'h7, filter: 1'b1, src: COCD_SRC_IRC,
                  wdt: COCD_WDT_ALWAYS, reset_pin: 1'b1, secure: 1'b1,
                  low_power: 1'b0, lvl: COCD_LVL_LOW};
      latched_ff <= 1'b0;
      bad_opt_ff <= 1'b0;
    end else if (!latched_ff) begin
      opt_ff <= nxt_opt;
      latched_ff <= 1'b1;
      bad_opt_ff <= fuse_word.filter &&
                    fuse_word.presc < `COCD_PRESC_MIN_FILT;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Decoded outputs.
  logic is_irc;
  logic rtc_pins;
  logic ext_rc;
  logic lv_reset;
  assign is_irc = opt_ff.src == COCD_SRC_IRC;
  assign rtc_pins = opt_ff.src == COCD_SRC_IRC_RTC;
  assign ext_rc = opt_ff.src == COCD_SRC_EXT_RC;

  always_comb begin
    unique case (opt_ff.lvl)
      COCD_LVL_HIGH: lv_reset = supply_below_2v4;
      COCD_LVL_MID: lv_reset = supply_below_2v1;
      default: lv_reset = supply_below_2v1;
    endcase
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cpu_div_log2 <= 3'h7;
      clk_src_sel <= 6'h01;
      osc_in_oe <= 1'b0;
      osc_out_oe <= 1'b0;
      osc_in_out <= 1'b0;
      osc_out_out <= 1'b0;
      port1_bit2_oe <= 1'b0;
      port1_bit2_out <= 1'b0;
      port1_bit2_function <= 1'b0;
      wdt_run <= 1'b0;
      rom_read_grant <= 1'b0;
      low_power_en <= 1'b0;
      chip_reset_req <= 1'b1;
      supply_below_2v4_flag <= 1'b0;
      supply_below_3v6_flag <= 1'b0;
    end else begin
      // One divide code serves both the high and the low clock.
      cpu_div_log2 <= opt_ff.presc;
      clk_src_sel <= opt_ff.src;
      // Pins become GPIO only where the source leaves them free.
      osc_in_oe <= is_irc && osc_in_o;
      osc_in_out <= 1'b0;
      osc_out_oe <= (is_irc || ext_rc) && osc_out_o;
      osc_out_out <= 1'b0;
      // Open drain: only the low level is driven.
      port1_bit2_function <= !opt_ff.reset_pin;
      port1_bit2_out <= 1'b0;
      port1_bit2_oe <= !opt_ff.reset_pin && !port1_bit2_o;
      unique case (opt_ff.wdt)
        COCD_WDT_ALWAYS: wdt_run <= 1'b1;
        COCD_WDT_ENABLE: wdt_run <= !sleep_mode;
        default: wdt_run <= 1'b0;
      endcase
      rom_read_grant <= rom_read_req && !opt_ff.secure;
      low_power_en <= opt_ff.low_power;
      chip_reset_req <= !latched_ff || lv_reset ||
                        (opt_ff.reset_pin && !ext_reset_n_pin);
      supply_below_2v4_flag <= opt_ff.lvl == COCD_LVL_MID &&
                               supply_below_2v4;
      supply_below_3v6_flag <= opt_ff.lvl == COCD_LVL_HIGH &&
                               supply_below_3v6;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Event status, mask and interrupt.
  logic [`COCD_EV_W-1:0] status_ff;
  logic [`COCD_EV_W-1:0] mask_ff;
  logic [`COCD_EV_W-1:0] ev;
  logic [`COCD_EV_W-1:0] w1c;
  logic [`COCD_EV_W-1:0] mask_wr;
  logic mask_we;
  logic bad_seen_ff;

  assign ev[`COCD_EV_LVRESET] = lv_reset;
  assign ev[`COCD_EV_BELOW24] = supply_below_2v4_flag;
  assign ev[`COCD_EV_BELOW36] = supply_below_3v6_flag;
  assign ev[`COCD_EV_EXTRST] = opt_ff.reset_pin && !ext_reset_n_pin;
  assign ev[`COCD_EV_BADOPT] = bad_opt_ff && !bad_seen_ff;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      bad_seen_ff <= 1'b0;
    end else if (bad_opt_ff) begin
      bad_seen_ff <= 1'b1;
    end
  end

  // A new event wins over a clear in the same cycle.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      status_ff <= `COCD_STATUS_RST;
    end else begin
      status_ff <= (status_ff & ~w1c) | ev;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      mask_ff <= `COCD_MASK_RST;
    end else if (mask_we) begin
      mask_ff <= mask_wr;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status_ff & mask_ff);
    end
  end

  //////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave. Address and data are taken together or apart.
  logic [ADDR_W-1:0] aw_ff;
  logic aw_have_ff;
  logic w_have_ff;
  logic [31:0] wd_ff;
  logic [3:0] ws_ff;
  logic do_write;
  logic w_hit;

  assign do_write = aw_have_ff && w_have_ff && !s_bvalid;
  assign w_hit = aw_ff == `COCD_OFS_STATUS || aw_ff == `COCD_OFS_MASK;
  assign w1c = (do_write && aw_ff == `COCD_OFS_STATUS && ws_ff[0]) ?
               wd_ff[`COCD_EV_W-1:0] : '0;
  assign mask_we = do_write && aw_ff == `COCD_OFS_MASK && ws_ff[0];
  assign mask_wr = wd_ff[`COCD_EV_W-1:0];

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      aw_have_ff <= 1'b0;
      w_have_ff <= 1'b0;
      aw_ff <= '0;
      wd_ff <= 32'h00000000;
      ws_ff <= 4'h0;
      s_awready <= 1'b0;
      s_wready <= 1'b0;
      s_bvalid <= 1'b0;
      s_bresp <= 2'h0;
    end else begin
      s_awready <= !aw_have_ff && !s_awready && !s_bvalid;
      s_wready <= !w_have_ff && !s_wready && !s_bvalid;
      if (s_awvalid && s_awready) begin
        aw_ff <= s_awaddr;
        aw_have_ff <= 1'b1;
        s_awready <= 1'b0;
      end
      if (s_wvalid && s_wready) begin
        wd_ff <= s_wdata;
        ws_ff <= s_wstrb;
        w_have_ff <= 1'b1;
        s_wready <= 1'b0;
      end
      if (do_write) begin
        aw_have_ff <= 1'b0;
        w_have_ff <= 1'b0;
        s_bvalid <= 1'b1;
        // Options and flags are read-only: writes there are refused.
        s_bresp <= w_hit ? 2'h0 : 2'h2;
      end else if (s_bvalid && s_bready) begin
        s_bvalid <= 1'b0;
      end
    end
  end

  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h00000000;
    unique case (s_araddr)
      `COCD_OFS_OPTION: rd_mux[15:0] = {1'b0, opt_ff.lvl,
          opt_ff.low_power, opt_ff.secure, opt_ff.reset_pin,
          opt_ff.wdt[1:0], opt_ff.src[2:0], opt_ff.filter, opt_ff.presc};
      `COCD_OFS_STATUS: rd_mux[`COCD_EV_W-1:0] = status_ff;
      `COCD_OFS_MASK: rd_mux[`COCD_EV_W-1:0] = mask_ff;
      `COCD_OFS_FLAGS: rd_mux[1:0] = {supply_below_3v6_flag,
          supply_below_2v4_flag};
      default: rd_mux = 32'h00000000;
    endcase
  end

  logic r_hit;
  assign r_hit = s_araddr == `COCD_OFS_OPTION ||
                 s_araddr == `COCD_OFS_STATUS ||
                 s_araddr == `COCD_OFS_MASK ||
                 s_araddr == `COCD_OFS_FLAGS;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      s_arready <= 1'b0;
      s_rvalid <= 1'b0;
      s_rdata <= 32'h00000000;
      s_rresp <= 2'h0;
    end else begin
      s_arready <= !s_rvalid && !s_arready && s_arvalid;
      if (s_arvalid && s_arready) begin
        s_rvalid <= 1'b1;
        s_rdata <= rd_mux;
        s_rresp <= r_hit ? 2'h0 : 2'h2;
      end else if (s_rvalid && s_rready) begin
        s_rvalid <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Checks.
  property p_filter_div;
    @(posedge sys_clk) disable iff (!resetn)
      latched_ff && opt_ff.filter |=> cpu_div_log2 >= 3'h2;
  endproperty
  a_filter_div: assert property (p_filter_div)
    else $error("divide below 4 with filter on");

  property p_div_follow;
    @(posedge sys_clk) disable iff (!resetn)
      latched_ff |=> cpu_div_log2 == $past(opt_ff.presc);
  endproperty
  a_div_follow: assert property (p_div_follow)
    else $error("divide does not follow option");

  property p_opt_hold;
    @(posedge sys_clk) disable iff (!resetn)
      latched_ff |=> $stable(opt_ff);
  endproperty
  a_opt_hold: assert property (p_opt_hold)
    else $error("options changed after latch");

  property p_wdt_always;
    @(posedge sys_clk) disable iff (!resetn)
      latched_ff && opt_ff.wdt == COCD_WDT_ALWAYS |=> wdt_run;
  endproperty
  a_wdt_always: assert property (p_wdt_always)
    else $error("watchdog stopped while always on");

  property p_wdt_sleep;
    @(posedge sys_clk) disable iff (!resetn)
      opt_ff.wdt != COCD_WDT_ALWAYS && sleep_mode |=> !wdt_run;
  endproperty
  a_wdt_sleep: assert property (p_wdt_sleep)
    else $error("watchdog runs asleep");

  property p_secure;
    @(posedge sys_clk) disable iff (!resetn)
      opt_ff.secure |=> !rom_read_grant;
  endproperty
  a_secure: assert property (p_secure)
    else $error("ROM read granted while secured");

  property p_lv_low;
    @(posedge sys_clk) disable iff (!resetn)
      opt_ff.lvl != COCD_LVL_HIGH && supply_below_2v1 |=> chip_reset_req;
  endproperty
  a_lv_low: assert property (p_lv_low)
    else $error("no reset below 2.1 V");

  property p_lv_high;
    @(posedge sys_clk) disable iff (!resetn)
      opt_ff.lvl == COCD_LVL_HIGH && supply_below_2v4 |=> chip_reset_req;
  endproperty
  a_lv_high: assert property (p_lv_high)
    else $error("no reset below 2.4 V");

  property p_pin_od;
    @(posedge sys_clk) disable iff (!resetn)
      opt_ff.reset_pin |=> !port1_bit2_oe && !port1_bit2_out;
  endproperty
  a_pin_od: assert property (p_pin_od)
    else $error("reset pin driven as port");

  property p_rtc_pins;
    @(posedge sys_clk) disable iff (!resetn)
      rtc_pins |=> !osc_in_oe && !osc_out_oe;
  endproperty
  a_rtc_pins: assert property (p_rtc_pins)
    else $error("crystal pins driven");

  c_irq: cover property (@(posedge sys_clk) disable iff (!resetn)
    $rose(irq));
  c_write: cover property (@(posedge sys_clk) disable iff (!resetn)
    s_bvalid && s_bready);
  c_sleep_wdt: cover property (@(posedge sys_clk) disable iff (!resetn)
    opt_ff.wdt == COCD_WDT_ENABLE && sleep_mode);
endmodule : cocd_option_decode

// ---- hw/cocd_pkg.sv ----
/*
  Types of the option decoder: option fields and the decoded word.
  Assumes cocd_map.svh is on the include path.
*/
package cocd_pkg;
  `include "cocd_map.svh"

  // Clock source select, one-hot.
  typedef enum logic [5:0] {
    COCD_SRC_IRC = 6'h01,
    COCD_SRC_IRC_RTC = 6'h02,
    COCD_SRC_EXT_RC = 6'h04,
    COCD_SRC_XTAL_LOW = 6'h08,
    COCD_SRC_XTAL_HIGH = 6'h10,
    COCD_SRC_XTAL_STD = 6'h20
  } cocd_src_e;

  typedef enum logic [2:0] {
    COCD_WDT_ALWAYS = 3'h1,
    COCD_WDT_ENABLE = 3'h2,
    COCD_WDT_DISABLE = 3'h4
  } cocd_wdt_e;

  typedef enum logic [2:0] {
    COCD_LVL_LOW = 3'h1,
    COCD_LVL_MID = 3'h2,
    COCD_LVL_HIGH = 3'h4
  } cocd_lvl_e;

  // Raw fuse word as it arrives from the option array.
  typedef struct packed {
    logic [1:0] lvl;
    logic low_power;
    logic secure;
    logic reset_pin;
    logic [1:0] wdt;
    logic [2:0] src;
    logic filter;
    logic [2:0] presc;
  } cocd_fuse_s;

  // Decoded, latched settings.
  typedef struct packed {
    logic [2:0] presc;
    logic filter;
    cocd_src_e src;
    cocd_wdt_e wdt;
    logic reset_pin;
    logic secure;
    logic low_power;
    cocd_lvl_e lvl;
  } cocd_opt_s;
endpackage : cocd_pkg

// ---- tb/cocd_fuse_model.sv ----
/*
  Model of the one-time option fuse array and the oscillator pins seen
  from outside the decoder.
  Assumes the bench programs the wanted word before it pulls resetn low.
*/
module cocd_fuse_model
  import cocd_pkg::*;
(
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic resetn,
  // Wanted option word and leave to program a forbidden divide.
  input wire cocd_fuse_s want,
  input wire logic allow_bad,
  // Fuse array and far side of the oscillator pins.
  output cocd_fuse_s fuse_word,
  output logic osc_in_pin,
  output logic osc_out_pin
);
  timeunit 1ns;
  timeprecision 1ps;

  cocd_fuse_s pick;

  ////////////////////////////////////////////////////////////////////
  always_comb begin
    pick = want;
    if (pick.filter && pick.presc < 3'h2 && !allow_bad) begin
      pick.presc = 3'h2;
    end
    // The internal 16 MHz source needs divide 16 to stay at 1 MIPS.
    if (pick.low_power && pick.src < 3'h2 && pick.presc < 3'h4) begin
      pick.presc = 3'h4;
    end
  end

  // The array only takes a new word while the chip is held in reset.
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      fuse_word <= pick;
    end
  end

  // Released pins show a level that changes every cycle.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      osc_in_pin <= 1'b0;
    end else begin
      osc_in_pin <= ~osc_in_pin;
    end
  end
  assign osc_out_pin = ~osc_in_pin;
endmodule : cocd_fuse_model

// ---- tb/test_cocd_option_decode.sv ----
/*
  Self-checking bench of the option decoder: every fuse field, decoded
  pins and policies, and the register bus with status, mask and irq.
  Assumes cocd_pkg, the decoder and cocd_fuse_model are compiled first.
*/
`include "cocd_map.svh"
module test_cocd_option_decode import cocd_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  logic sys_clk, resetn, supply_below_2v1, supply_below_2v4;
  logic supply_below_3v6, sleep_mode, ext_reset_n_pin, rom_read_req;
  logic osc_in_o, osc_out_o, port1_bit2_o, allow_bad;
  logic osc_in_pin, osc_out_pin, port1_bit2_in, osc_in_ext, osc_out_ext;
  cocd_fuse_s want, fuse_word;
  logic [2:0] cpu_div_log2;
  logic [5:0] clk_src_sel;
  logic osc_in_oe, osc_out_oe, osc_in_out, osc_out_out, port1_bit2_oe;
  logic port1_bit2_out, port1_bit2_function, wdt_run, rom_read_grant;
  logic low_power_en, chip_reset_req, supply_below_2v4_flag;
  logic supply_below_3v6_flag, irq;
  logic [7:0] s_awaddr, s_araddr;
  logic [31:0] s_wdata, s_rdata;
  logic [3:0] s_wstrb;
  logic [1:0] s_bresp, s_rresp;
  logic s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
  logic s_arvalid, s_arready, s_rvalid, s_rready;
  int failures, total_checks;

  ////////////////////////////////////////////////////////////////////
  cocd_option_decode u_cocd_option_decode (
    .sys_clk, .resetn, .fuse_word, .supply_below_2v1, .supply_below_2v4,
    .supply_below_3v6, .sleep_mode, .ext_reset_n_pin, .rom_read_req,
    .osc_in_pin, .osc_out_pin, .port1_bit2_in, .osc_in_o, .osc_out_o,
    .port1_bit2_o, .cpu_div_log2, .clk_src_sel, .osc_in_oe, .osc_out_oe,
    .osc_in_out, .osc_out_out, .port1_bit2_oe, .port1_bit2_out,
    .port1_bit2_function, .wdt_run, .rom_read_grant, .low_power_en,
    .chip_reset_req, .supply_below_2v4_flag, .supply_below_3v6_flag, .irq,
    .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb, .s_wvalid,
    .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid,
    .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready
  );

  cocd_fuse_model u_cocd_fuse_model (
    .sys_clk, .resetn, .want, .allow_bad, .fuse_word,
    .osc_in_pin(osc_in_ext), .osc_out_pin(osc_out_ext)
  );

  // Pin levels: a driven pin is pulled low, a released one shows the level from the fuse model.
  assign osc_in_pin = osc_in_oe ? 1'b0 : osc_in_ext;
  assign osc_out_pin = osc_out_oe ? 1'b0 : osc_out_ext;
  assign port1_bit2_in = port1_bit2_oe ? 1'b0 : ~osc_out_ext;

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  initial begin
    #200000;
    failures++;
    results;
  end

  ////////////////////////////////////////////////////////////////////
  task results;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : results

  task check_out(input string what, input logic [31:0] exp,
                 input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %0h seen %0h", what, exp, got);
    end
  endtask : check_out

  task check_bus(input string what, input logic [31:0] exp,
                 input logic [31:0] got);
    check_out({"bus ", what}, exp, got);
  endtask : check_bus

  function automatic logic [2:0] exp_div();
    if (fuse_word.filter && fuse_word.presc < 3'h2) begin
      return 3'h2;
    end
    return fuse_word.presc;
  endfunction : exp_div

  task bus_wr(input logic [7:0] a, input logic [31:0] d,
              output logic [1:0] r);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge sys_clk);
    s_awaddr <= a;
    s_awvalid <= 1'b1;
    s_wdata <= d;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge sys_clk);
      if (!aw_ok && s_awready === 1'b1) begin
        aw_ok = 1'b1;
        s_awvalid <= 1'b0;
      end
      if (!w_ok && s_wready === 1'b1) begin
        w_ok = 1'b1;
        s_wvalid <= 1'b0;
      end
    end
    while (s_bvalid !== 1'b1) @(posedge sys_clk);
    r = s_bresp;
    s_bready <= 1'b0;
  endtask : bus_wr

  task bus_rd(input logic [7:0] a, output logic [31:0] d,
              output logic [1:0] r);
    @(posedge sys_clk);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do @(posedge sys_clk); while (s_arready !== 1'b1);
    s_arvalid <= 1'b0;
    while (s_rvalid !== 1'b1) @(posedge sys_clk);
    d = s_rdata;
    r = s_rresp;
    s_rready <= 1'b0;
  endtask : bus_rd

  task reg_wr(input logic [7:0] a, input logic [31:0] d,
              input logic [1:0] er);
    logic [1:0] r;
    bus_wr(a, d, r);
    check_bus("bresp", er, r);
  endtask : reg_wr

  task reg_rd(input logic [7:0] a, input logic [31:0] ed,
              input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    bus_rd(a, d, r);
    check_bus("rresp", er, r);
    check_bus("rdata", ed, d);
  endtask : reg_rd

  task do_reset;
    @(posedge sys_clk);
    resetn <= 1'b0;
    {supply_below_2v1, supply_below_2v4, supply_below_3v6} <= '0;
    ext_reset_n_pin <= 1'b1;
    repeat (5) @(posedge sys_clk);
    #1;
    check_out("rst_req", 1, chip_reset_req);
    check_out("rst_div", 7, cpu_div_log2);
    check_out("rst_src", 1, clk_src_sel);
    @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge sys_clk);
    #1;
  endtask : do_reset

  task check_decode;
    logic lvr;
    logic [2:0] s;
    lvr = fuse_word.lvl < 2'h2 ? supply_below_2v1 : supply_below_2v4;
    s = fuse_word.src > 3'h5 ? 3'h5 : fuse_word.src;
    check_out("div", exp_div(), cpu_div_log2);
    check_out("src", 6'h01 << s, clk_src_sel);
    check_out("in_oe", osc_in_o && s == 3'h0, osc_in_oe);
    check_out("out_oe", osc_out_o && (s == 3'h0 || s == 3'h2),
              osc_out_oe);
    check_out("wdt", fuse_word.wdt == 2'h0 ||
              (fuse_word.wdt == 2'h1 && !sleep_mode), wdt_run);
    check_out("pfn", !fuse_word.reset_pin, port1_bit2_function);
    check_out("poe", !fuse_word.reset_pin && !port1_bit2_o,
              port1_bit2_oe);
    check_out("rom", rom_read_req && !fuse_word.secure,
              rom_read_grant);
    check_out("lowpwr", fuse_word.low_power, low_power_en);
    check_out("reset", lvr || (fuse_word.reset_pin && !ext_reset_n_pin),
              chip_reset_req);
    check_out("f24", fuse_word.lvl == 2'h1 && supply_below_2v4,
              supply_below_2v4_flag);
    check_out("f36", fuse_word.lvl > 2'h1 && supply_below_3v6,
              supply_below_3v6_flag);
    check_out("pin_out", 0, {osc_in_out, osc_out_out,
              port1_bit2_out});
  endtask : check_decode

  ////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    logic bad;
    failures = 0;
    total_checks = 0;
    {resetn, supply_below_2v1, supply_below_2v4, supply_below_3v6} = '0;
    {sleep_mode, rom_read_req, osc_in_o, osc_out_o, port1_bit2_o} = '0;
    ext_reset_n_pin = 1'b1;
    allow_bad = 1'b1;
    want = '0;
    {s_awaddr, s_araddr, s_wdata} = '0;
    s_wstrb = 4'hF;
    {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
    void'($urandom(69));
    for (int i = 0; i < 10; i++) begin
      want <= '{lvl: 2'(i), low_power: i[3] & ~i[0], secure: i[1],
                reset_pin: i[0], wdt: 2'(i), src: 3'(i),
                filter: i[0] ^ i[2] ^ i[3], presc: 3'(i)};
      allow_bad <= ~i[3];
      do_reset;
      check_decode;
      bad = fuse_word.filter && fuse_word.presc < 3'h2;
      reg_rd(`COCD_OFS_STATUS, {27'h0, bad, 4'h0}, 2'h0);
      bus_rd(`COCD_OFS_OPTION, d, r);
      check_bus("opt_div", {fuse_word.filter, exp_div()}, d[3:0]);
      check_bus("opt_bits", {fuse_word.low_power, fuse_word.secure,
                fuse_word.reset_pin}, d[11:9]);
      check_bus("opt_lvl", 3'h1 << (fuse_word.lvl > 2'h1 ? 2'h2 :
                fuse_word.lvl), d[14:12]);
      reg_wr(`COCD_OFS_OPTION, ~d, 2'h2);
      reg_rd(`COCD_OFS_OPTION, d, 2'h0);
      repeat (4) begin
        @(posedge sys_clk);
        {supply_below_2v1, supply_below_2v4, supply_below_3v6, sleep_mode,
         ext_reset_n_pin, rom_read_req, osc_in_o, osc_out_o,
         port1_bit2_o} <= 9'($urandom);
        repeat (2) @(posedge sys_clk);
        #1;
        check_decode;
      end
    end
    // Last fuse word has the middle level: events, mask and irq.
    @(posedge sys_clk);
    {supply_below_2v1, supply_below_2v4, supply_below_3v6} <= '0;
    ext_reset_n_pin <= 1'b1;
    reg_wr(`COCD_OFS_STATUS, 32'h1F, 2'h0);
    reg_rd(`COCD_OFS_STATUS, 32'h0, 2'h0);
    reg_wr(`COCD_OFS_MASK, 32'h02, 2'h0);
    reg_rd(`COCD_OFS_MASK, 32'h02, 2'h0);
    @(posedge sys_clk);
    supply_below_2v4 <= 1'b1;
    repeat (3) @(posedge sys_clk);
    #1;
    check_decode;
    reg_rd(`COCD_OFS_FLAGS, 32'h1, 2'h0);
    @(posedge sys_clk);
    supply_below_2v4 <= 1'b0;
    supply_below_2v1 <= 1'b1;
    repeat (3) @(posedge sys_clk);
    supply_below_2v1 <= 1'b0;
    reg_rd(`COCD_OFS_STATUS, 32'h03, 2'h0);
    check_out("irq_set", 1, irq);
    reg_wr(`COCD_OFS_STATUS, 32'h02, 2'h0);
    repeat (3) @(posedge sys_clk);
    #1;
    check_out("irq_clr", 0, irq);
    reg_rd(`COCD_OFS_STATUS, 32'h01, 2'h0);
    reg_wr(`COCD_OFS_MASK, 32'h01, 2'h0);
    repeat (3) @(posedge sys_clk);
    #1;
    check_out("irq_mask", 1, irq);
    reg_rd(8'h10, 32'h0, 2'h2);
    reg_wr(8'h14, 32'h1, 2'h2);
    reg_wr(`COCD_OFS_FLAGS, 32'h3, 2'h2);
    results;
  end
endmodule : test_cocd_option_decode
